// >>> core/ple_regs.svh
// register map, field positions, reset values and fixed sizes of the logic cell
// assumes a byte-addressed bus with 32-bit data words
`ifndef PLE_REGS_SVH
`define PLE_REGS_SVH

`define PLE_ADR_W 8
`define PLE_DAT_W 32
`define PLE_ADR_CFG 8'h00
`define PLE_ADR_LUT 8'h04
`define PLE_ADR_STAT 8'h08

`define PLE_CFG_W 11
`define PLE_CFG_MODE_LO 0
`define PLE_CFG_MODE_HI 1
`define PLE_CFG_CIN_SEL 2
`define PLE_CFG_REG_SRC 3
`define PLE_CFG_LOCAL_SEL 4
`define PLE_CFG_GLOBAL_SEL 5
`define PLE_CFG_SCHEME_LO 6
`define PLE_CFG_SCHEME_HI 8
`define PLE_CFG_CHIPRST_EN 9
`define PLE_CFG_CASC_OR 10
`define PLE_CFG_RST 11'h000

`define PLE_LUT_W 16
`define PLE_LUT_RST 16'h0000
`define PLE_LUT_DATA_LO 0
`define PLE_LUT_DATA_HI 7
`define PLE_LUT_CARRY_LO 8
`define PLE_LUT_CARRY_HI 15

`define PLE_STAT_Q 0
`define PLE_STAT_LUT 1
`define PLE_STAT_CARRY 2
`define PLE_STAT_CASC 3
`define PLE_STAT_TBUS 4

`define PLE_TBUS_N 4
`define PLE_TBUS_CNT_W 3
`define PLE_WORD_ZERO 32'h0000_0000

`endif

// >>> core/ple_pkg.sv
// types shared by the logic cell files
// assumes ple_regs.svh is on the include path
package ple_pkg;
`include "ple_regs.svh"

	typedef enum logic [1:0] {
		PLE_MODE_NORMAL,
		PLE_MODE_ARITH,
		PLE_MODE_UPDOWN,
		PLE_MODE_CLRCNT
	} ple_mode_e;

	typedef enum logic [2:0] {
		PLE_CTL_CLR,
		PLE_CTL_PRE,
		PLE_CTL_CLR_PRE,
		PLE_CTL_LOAD_CLR,
		PLE_CTL_LOAD_PRE,
		PLE_CTL_LOAD
	} ple_ctrl_e;

	typedef struct packed {
		logic [`PLE_CFG_W-1:0] cfg;
		logic [`PLE_LUT_W-1:0] lut;
		logic stored;
		logic local_out;
		logic global_out;
		logic carry_out;
		logic cascade_out;
		logic lut_out;
		logic tbus;
		logic ack;
		logic [`PLE_DAT_W-1:0] rdata;
	} ple_state_s;

endpackage

// >>> core/ple_tbus.sv
// resolver for an emulated internal tri-state bus
// assumes drivers and enables are synchronous to the cell clock
`timescale 1ns/1ps
`include "ple_regs.svh"

module ple_tbus (
	input wire logic [`PLE_TBUS_N-1:0] drv_data_i,
	input wire logic [`PLE_TBUS_N-1:0] drv_oe_i,
	output logic bus_o
);
	logic [`PLE_TBUS_CNT_W-1:0] n_on;
	logic sel_val;

	always_comb
	begin
		n_on = '0;
		sel_val = 1'b1;
		for (int i = 0; i < `PLE_TBUS_N; i++)
		begin
			if (drv_oe_i[i])
			begin
				n_on = n_on + `PLE_TBUS_CNT_W'(1);
				sel_val = drv_data_i[i];
			end
		end
		// floating reads high, contention reads low
		if (n_on == '0)
			bus_o = 1'b1;
		else if (n_on == `PLE_TBUS_CNT_W'(1))
			bus_o = sel_val;
		else
			bus_o = 1'b0;
	end
endmodule // ple_tbus

// >>> core/ple_cell.sv
// programmable logic cell: lookup table, carry and cascade paths, one register,
// clear/preset control and a tri-state bus emulator, configured over classic wishbone
// assumes all pins synchronous to clk_i; asynchronous controls take effect at the next edge
`timescale 1ns/1ps
`include "ple_regs.svh"

module ple_cell (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PLE_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [`PLE_DAT_W-1:0] wb_dat_i,
	output logic [`PLE_DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cell_input_a_i,
	input wire logic cell_input_b_i,
	input wire logic cell_input_c_i,
	input wire logic cell_input_d_i,
	input wire logic carry_in_i,
	input wire logic cascade_in_i,
	input wire logic clk_ena_i,
	input wire logic cluster_ctrl_a_n_i,
	input wire logic cluster_ctrl_b_n_i,
	input wire logic chip_reset_n_i,
	input wire logic [`PLE_TBUS_N-1:0] tbus_data_i,
	input wire logic [`PLE_TBUS_N-1:0] tbus_oe_i,
	output logic local_out_o,
	output logic global_out_o,
	output logic carry_out_o,
	output logic cascade_out_o,
	output logic tbus_o
);
	import ple_pkg::*;

	ple_state_s st_reg;
	ple_state_s st_next;
	ple_mode_e mode;
	ple_ctrl_e scheme;
	logic tbus_res;
	logic inv;
	logic q;
	logic lut_c;
	logic lut_res;
	logic carry_res;
	logic cnt_val;
	logic data_d;
	logic d_eff;
	logic stored_sync;
	logic ctl_a;
	logic ctl_b;
	logic clr_path;
	logic pre_path;
	logic chip_rst;
	logic q_next;
	logic req;
	logic [`PLE_DAT_W-1:0] wr_word;

	function automatic logic lut3(input logic [7:0] mask, input logic [2:0] idx);
		lut3 = mask[idx];
	endfunction

	function automatic logic lut4(input logic [15:0] mask, input logic [3:0] idx);
		lut4 = mask[idx];
	endfunction

	function automatic logic casc(input logic v, input logic cin, input logic use_or);
		casc = use_or ? (v | cin) : (v & cin);
	endfunction

	function automatic logic [`PLE_DAT_W-1:0] merge(
		input logic [`PLE_DAT_W-1:0] old_v,
		input logic [`PLE_DAT_W-1:0] new_v,
		input logic [3:0] sel
	);
		merge = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				merge[i*8 +: 8] = new_v[i*8 +: 8];
		end
	endfunction

	ple_tbus u_tbus (
		.drv_data_i(tbus_data_i),
		.drv_oe_i(tbus_oe_i),
		.bus_o(tbus_res)
	);

	always_comb
	begin
		st_next = st_reg;
		mode = ple_mode_e'(st_reg.cfg[`PLE_CFG_MODE_HI:`PLE_CFG_MODE_LO]);
		scheme = ple_ctrl_e'(st_reg.cfg[`PLE_CFG_SCHEME_HI:`PLE_CFG_SCHEME_LO]);
		// stored bit is kept inverted only in the PLE_CTL_LOAD_PRE scheme for preset-by-inversion
		inv = (scheme == PLE_CTL_LOAD_PRE);
		q = inv ? ~st_reg.stored : st_reg.stored;
		lut_c = st_reg.cfg[`PLE_CFG_CIN_SEL] ? carry_in_i : cell_input_c_i;
		lut_res = 1'b0;
		carry_res = carry_in_i;
		cnt_val = q;
		data_d = q;
		st_next.cascade_out = cascade_in_i;

		case (mode)
			PLE_MODE_NORMAL:
			begin
				lut_res = lut4(st_reg.lut, {cell_input_d_i, lut_c, cell_input_b_i, cell_input_a_i});
				st_next.cascade_out = casc(lut_res, cascade_in_i, st_reg.cfg[`PLE_CFG_CASC_OR]);
				data_d = st_reg.cfg[`PLE_CFG_REG_SRC] ? cell_input_d_i : lut_res;
			end
			PLE_MODE_ARITH:
			begin
				lut_res = lut3(st_reg.lut[`PLE_LUT_DATA_HI:`PLE_LUT_DATA_LO],
					{carry_in_i, cell_input_b_i, cell_input_a_i});
				carry_res = lut3(st_reg.lut[`PLE_LUT_CARRY_HI:`PLE_LUT_CARRY_LO],
					{carry_in_i, cell_input_b_i, cell_input_a_i});
				st_next.cascade_out = casc(lut_res, cascade_in_i, st_reg.cfg[`PLE_CFG_CASC_OR]);
				data_d = st_reg.cfg[`PLE_CFG_REG_SRC] ? cell_input_d_i : lut_res;
			end
			PLE_MODE_UPDOWN:
			begin
				// b is direction, a counts, d loads c
				lut_res = lut3(st_reg.lut[`PLE_LUT_DATA_HI:`PLE_LUT_DATA_LO],
					{carry_in_i, cell_input_b_i, q});
				carry_res = lut3(st_reg.lut[`PLE_LUT_CARRY_HI:`PLE_LUT_CARRY_LO],
					{carry_in_i, cell_input_b_i, q});
				cnt_val = cell_input_a_i ? lut_res : q;
				data_d = cell_input_d_i ? cell_input_c_i : cnt_val;
				st_next.cascade_out = casc(lut_res, cascade_in_i, st_reg.cfg[`PLE_CFG_CASC_OR]);
			end
			PLE_MODE_CLRCNT:
			begin
				// cascade input acts as active-low synchronous clear
				lut_res = lut3(st_reg.lut[`PLE_LUT_DATA_HI:`PLE_LUT_DATA_LO],
					{carry_in_i, cell_input_b_i, q});
				carry_res = lut3(st_reg.lut[`PLE_LUT_CARRY_HI:`PLE_LUT_CARRY_LO],
					{carry_in_i, cell_input_b_i, q});
				cnt_val = cell_input_a_i ? lut_res : q;
				data_d = (cell_input_d_i ? cell_input_c_i : cnt_val) & cascade_in_i;
				st_next.cascade_out = lut_res;
			end
			default:
			begin
				lut_res = 1'b0;
			end
		endcase

		// clock enable holds the register in every mode
		d_eff = clk_ena_i ? data_d : q;
		stored_sync = inv ? ~d_eff : d_eff;

		// control lines are active low
		ctl_a = ~cluster_ctrl_a_n_i;
		ctl_b = ~cluster_ctrl_b_n_i;
		clr_path = 1'b0;
		pre_path = 1'b0;
		case (scheme)
			PLE_CTL_CLR:
			begin
				clr_path = ctl_a | ctl_b;
			end
			PLE_CTL_PRE:
			begin
				pre_path = ctl_a;
			end
			PLE_CTL_CLR_PRE:
			begin
				pre_path = ctl_a;
				clr_path = ctl_b;
			end
			PLE_CTL_LOAD_CLR:
			begin
				pre_path = ctl_a & cell_input_c_i;
				clr_path = (ctl_a & ~cell_input_c_i) | ctl_b;
			end
			PLE_CTL_LOAD_PRE:
			begin
				pre_path = ctl_a & cell_input_c_i;
				clr_path = (ctl_a & ~cell_input_c_i) | ctl_b;
			end
			PLE_CTL_LOAD:
			begin
				pre_path = ctl_a & cell_input_c_i;
				clr_path = ctl_a & ~cell_input_c_i;
			end
			default:
			begin
				clr_path = 1'b0;
			end
		endcase

		chip_rst = st_reg.cfg[`PLE_CFG_CHIPRST_EN] & ~chip_reset_n_i;
		// chip reset, then clear, then load or preset, then clocked data
		if (chip_rst)
			st_next.stored = 1'b0;
		else if (clr_path)
			st_next.stored = 1'b0;
		else if (pre_path)
			st_next.stored = 1'b1;
		else
			st_next.stored = stored_sync;

		q_next = inv ? ~st_next.stored : st_next.stored;
		st_next.lut_out = lut_res;
		st_next.carry_out = carry_res;
		st_next.local_out = st_reg.cfg[`PLE_CFG_LOCAL_SEL] ? q_next : lut_res;
		st_next.global_out = st_reg.cfg[`PLE_CFG_GLOBAL_SEL] ? q_next : lut_res;
		st_next.tbus = tbus_res;

		// wishbone slave, one wait state, ack for one cycle
		req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		st_next.ack = req;
		st_next.rdata = `PLE_WORD_ZERO;
		wr_word = `PLE_WORD_ZERO;
		if (req)
		begin
			if (wb_adr_i == `PLE_ADR_CFG)
			begin
				wr_word = merge({{(`PLE_DAT_W-`PLE_CFG_W){1'b0}}, st_reg.cfg}, wb_dat_i, wb_sel_i);
				if (wb_we_i)
					st_next.cfg = wr_word[`PLE_CFG_W-1:0];
				else
					st_next.rdata = {{(`PLE_DAT_W-`PLE_CFG_W){1'b0}}, st_reg.cfg};
			end
			else if (wb_adr_i == `PLE_ADR_LUT)
			begin
				wr_word = merge({{(`PLE_DAT_W-`PLE_LUT_W){1'b0}}, st_reg.lut}, wb_dat_i, wb_sel_i);
				if (wb_we_i)
					st_next.lut = wr_word[`PLE_LUT_W-1:0];
				else
					st_next.rdata = {{(`PLE_DAT_W-`PLE_LUT_W){1'b0}}, st_reg.lut};
			end
			else if (wb_adr_i == `PLE_ADR_STAT)
			begin
				if (!wb_we_i)
				begin
					st_next.rdata[`PLE_STAT_Q] = q;
					st_next.rdata[`PLE_STAT_LUT] = st_reg.lut_out;
					st_next.rdata[`PLE_STAT_CARRY] = st_reg.carry_out;
					st_next.rdata[`PLE_STAT_CASC] = st_reg.cascade_out;
					st_next.rdata[`PLE_STAT_TBUS] = st_reg.tbus;
				end
			end
			else
			begin
				st_next.rdata = `PLE_WORD_ZERO;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg <= '0;
			st_reg.cfg <= `PLE_CFG_RST;
			st_reg.lut <= `PLE_LUT_RST;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o = st_reg.rdata;
	assign wb_ack_o = st_reg.ack;
	assign local_out_o = st_reg.local_out;
	assign global_out_o = st_reg.global_out;
	assign carry_out_o = st_reg.carry_out;
	assign cascade_out_o = st_reg.cascade_out;
	assign tbus_o = st_reg.tbus;
endmodule // ple_cell

// >>> test/ple_nbr.sv
// neighbour cell model: drives carry-in and cascade-in from its own flops
// assumes the same clock as the cell under test
`timescale 1ns/1ps

module ple_nbr (
	input wire logic clk_i,
	input wire logic carry_set_i,
	input wire logic casc_set_i,
	output logic carry_o,
	output logic casc_o
);
	always_ff @(posedge clk_i)
	begin
		carry_o <= carry_set_i;
		casc_o <= casc_set_i;
	end
endmodule // ple_nbr

// >>> test/ple_cell_properties.sv
// port checker for the logic cell, snoops the configuration word off the bus
// assumes masters write the configuration with all byte lanes enabled
`timescale 1ns/1ps
`include "ple_regs.svh"

module ple_cell_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [`PLE_ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [`PLE_DAT_W-1:0] wb_dat_i,
	input wire logic [`PLE_DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic clk_ena_i,
	input wire logic cluster_ctrl_a_n_i,
	input wire logic cluster_ctrl_b_n_i,
	input wire logic chip_reset_n_i,
	input wire logic [`PLE_TBUS_N-1:0] tbus_data_i,
	input wire logic [`PLE_TBUS_N-1:0] tbus_oe_i,
	input wire logic local_out_o,
	input wire logic tbus_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [10:0] cfg_q;
	logic rq;
	logic [2:0] sch;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cfg_q <= 11'h000;
		else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i == 4'hf)
			cfg_q <= wb_dat_i[10:0];
	end
	assign rq = !wb_ack_o && cfg_q[4];
	assign sch = cfg_q[8:6];
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
	property p_dzero; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
	a_dzero: assert property (p_dzero) else $error("read data without ack");
	property p_float; tbus_oe_i == 4'h0 |=> tbus_o; endproperty
	a_float: assert property (p_float) else $error("floating bus not high");
	property p_fight; $countones(tbus_oe_i) > 1 |=> !tbus_o; endproperty
	a_fight: assert property (p_fight) else $error("contended bus not low");
	property p_one; $onehot(tbus_oe_i) |=> tbus_o == $past(|(tbus_data_i & tbus_oe_i)); endproperty
	a_one: assert property (p_one) else $error("single driver not passed");
	property p_clr; rq && sch == 3'h0 && !(cluster_ctrl_a_n_i && cluster_ctrl_b_n_i) |=> !local_out_o; endproperty
	a_clr: assert property (p_clr) else $error("clear ignored");
	property p_crst; rq && cfg_q[9] && !chip_reset_n_i && sch != 3'h4 |=> !local_out_o; endproperty
	a_crst: assert property (p_crst) else $error("chip reset ignored");
	property p_hold;
		rq && sch == 3'h5 && !clk_ena_i && cluster_ctrl_a_n_i && !(cfg_q[9] && !chip_reset_n_i) |=> $stable(local_out_o);
	endproperty
	a_hold: assert property (p_hold) else $error("register moved while disabled");
	c_rd: cover property (wb_ack_o && !wb_we_i);
	c_clr: cover property (rq && sch == 3'h0 && !cluster_ctrl_b_n_i);
	c_fight: cover property ($countones(tbus_oe_i) > 1);
endmodule // ple_cell_chk

bind ple_cell ple_cell_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
	.wb_dat_o, .wb_ack_o, .clk_ena_i, .cluster_ctrl_a_n_i, .cluster_ctrl_b_n_i, .chip_reset_n_i, .tbus_data_i,
	.tbus_oe_i, .local_out_o, .tbus_o);

// >>> test/tb.sv
// self-checking bench for the logic cell over wishbone and cell pins
// assumes one wait state bus answers and one-cycle registered cell outputs
`timescale 1ns/1ps
`include "ple_regs.svh"

module tb;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0, td = 4'h0, toe = 4'h0;
	logic [31:0] dw = 32'h0, rd, dr;
	logic ia = 0, ib = 0, ic = 0, id = 0, cen = 0, can = 1, cbn = 1, crn = 1, ncy = 0, ncs = 0;
	logic cy, cs, lo, go, co, so, tb_o, ack;
	int mismatches = 0, total_checks = 0;
	ple_nbr nbr (.clk_i(clk_i), .carry_set_i(ncy), .casc_set_i(ncs), .carry_o(cy), .casc_o(cs));
	ple_cell uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .cell_input_a_i(ia), .cell_input_b_i(ib),
		.cell_input_c_i(ic), .cell_input_d_i(id), .carry_in_i(cy), .cascade_in_i(cs), .clk_ena_i(cen),
		.cluster_ctrl_a_n_i(can), .cluster_ctrl_b_n_i(cbn), .chip_reset_n_i(crn), .tbus_data_i(td),
		.tbus_oe_i(toe), .local_out_o(lo), .global_out_o(go), .carry_out_o(co), .cascade_out_o(so), .tbus_o(tb_o));
	initial forever #4 clk_i = ~clk_i;
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dw, sel} <= {2'b11, w, a, d, 4'hf};
		do
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		if (n >= 50)
			mismatches++;
		rd = dr;
		@(posedge clk_i);
		{cyc, stb} <= 2'b00;
	endtask
	task nx;
		@(posedge clk_i);
		#1;
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 8'h00, 0); chk(rd, 0);
		wb(0, 8'h04, 0); chk(rd, 0);
		wb(1, 8'h10, 32'hffff_ffff); wb(0, 8'h10, 0); chk(rd, 0);
		wb(1, 8'h04, 32'h0000_8000); wb(1, 8'h00, 0);
		@(posedge clk_i) {ia, ib, ic, id, ncs} <= 5'h1f;
		nx; nx; chk(lo, 1); chk(so, 1);
		@(posedge clk_i) ncs <= 0;
		nx; nx; chk(so, 0);
		@(posedge clk_i) id <= 0;
		nx; chk(lo, 0);
		wb(1, 8'h04, 32'h0000_e896); wb(1, 8'h00, 1);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge clk_i) {ncy, ib, ia} <= i[2:0];
			nx; nx; chk(lo, ^i[2:0]); chk(co, i[2:0] inside {3, 5, 6, 7});
		end
		wb(1, 8'h00, 32'h18);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk_i) {id, cen} <= 2'b11;
			nx; chk(lo, 1);
			@(posedge clk_i) {id, cen} <= 2'b00;
			nx; chk(lo, 1);
			@(posedge clk_i) {can, cbn} <= k ? 2'b01 : 2'b10;
			nx; chk(lo, 0);
			@(posedge clk_i) {can, cbn} <= 2'b11;
		end
		wb(1, 8'h00, 32'h158);
		@(posedge clk_i) {can, ic} <= 2'b01;
		nx; chk(lo, 1);
		@(posedge clk_i) ic <= 0;
		nx; chk(lo, 0);
		@(posedge clk_i) can <= 1;
		nx; chk(lo, 0);
		wb(1, 8'h00, 32'h98);
		@(posedge clk_i) {can, ic} <= 2'b01;
		nx; chk(lo, 1);
		@(posedge clk_i) cbn <= 0;
		nx; chk(lo, 0);
		wb(1, 8'h00, 32'h298);
		@(posedge clk_i) cbn <= 1;
		nx; chk(lo, 1);
		@(posedge clk_i) crn <= 0;
		nx; chk(lo, 0);
		@(posedge clk_i) {crn, can} <= 2'b11;
		wb(1, 8'h04, 32'h0000_a055); wb(1, 8'h00, 32'h192);
		@(posedge clk_i) {ia, cen} <= 2'b11;
		@(posedge clk_i) {ia, cen} <= 2'b00;
		nx; chk(lo, 1);
		@(posedge clk_i) {id, ic, cen} <= 3'b101;
		nx; chk(lo, 0);
		@(posedge clk_i) {id, cen} <= 2'b00;
		wb(1, 8'h00, 32'h193);
		@(posedge clk_i) ncs <= 1;
		nx;
		@(posedge clk_i) {ia, cen} <= 2'b11;
		@(posedge clk_i) {ia, cen} <= 2'b00;
		nx; chk(lo, 1);
		@(posedge clk_i) {ncs, cen} <= 2'b01;
		nx; nx; chk(lo, 0);
		@(posedge clk_i) cen <= 0;
		wb(1, 8'h00, 32'h130);
		@(posedge clk_i) cbn <= 0;
		nx; chk(lo, 1); chk(go, 1);
		@(posedge clk_i) {cbn, can, ic} <= 3'b101;
		nx; chk(lo, 0); chk(go, 0);
		@(posedge clk_i) can <= 1;
		@(posedge clk_i) {toe, td} <= 8'h00;
		nx; chk(tb_o, 1);
		@(posedge clk_i) {toe, td} <= 8'h33;
		nx; chk(tb_o, 0);
		@(posedge clk_i) {toe, td} <= 8'h44;
		nx; chk(tb_o, 1);
		@(posedge clk_i) td <= 0;
		nx; chk(tb_o, 0);
		wb(0, 8'h08, 0); chk(rd[4], 0); chk(rd[0], 0);
		test_done;
	end
	initial
	begin
		repeat (5000) @(posedge clk_i);
		mismatches++;
		test_done;
	end
endmodule // tb
